//--- uerl_pkg.sv
package uerl_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MUX_EQ_OFFSET = 8'h20;
    localparam logic [7:0] UP_EQ_OFFSET = 8'h21;
    localparam logic [7:0] LINK_CTRL_OFFSET = 8'h22;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MUX_EQ_RESET = 8'h00;
    localparam logic [7:0] UP_EQ_RESET = 8'h00;
    localparam logic [7:0] LINK_CTRL_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SECOND_EQ_LSB = 4;
    localparam int FIRST_EQ_LSB = 0;
    localparam int UP_EQ_LSB = 0;
    localparam int EQ_FIELD_W = 4;
    localparam int COMPLIANCE_STATUS_BIT = 7;
    localparam int LOW_FREQ_SIGNAL_EQUALIZE_BIT = 6;
    localparam int EXIT_DEBOUNCE_BIT = 5;
    localparam int DETECT_INHIBIT_BIT = 4;
    localparam int DETECT_PERIOD_LSB = 2;
    localparam int COMPLIANCE_SEL_LSB = 0;
    // bits of register 0x22 that software may write
    localparam logic [7:0] LINK_CTRL_WMASK = 8'h7F;

    // ------------------------------------------------------------
    // strap level to equalizer level mapping
    // ------------------------------------------------------------
    localparam logic [3:0] STRAP_LEVEL_0 = 4'h0;
    localparam logic [3:0] STRAP_LEVEL_1 = 4'h1;
    localparam logic [3:0] STRAP_LEVEL_2 = 4'h2;
    localparam logic [3:0] STRAP_LEVEL_3 = 4'h3;
    localparam logic [3:0] LFPS_ZERO_LEVEL = 4'h0;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [1:0] PERIOD_8MS = 2'h0;
    localparam logic [1:0] PERIOD_12MS = 2'h1;
    localparam logic [1:0] COMPLIANCE_BY_FSM = 2'h0;
    localparam logic [1:0] COMPLIANCE_DOWNSTREAM = 2'h1;
    localparam logic [1:0] COMPLIANCE_UPSTREAM = 2'h2;
    localparam logic [1:0] COMPLIANCE_NEVER = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 20000;
    localparam int EXIT_DEBOUNCE_US = 200;
    localparam int EXIT_DEBOUNCE_CYC = (EXIT_DEBOUNCE_US * CLK_KHZ + 999) / 1000;
    localparam int DETECT_SHORT_MS = 8;
    localparam int DETECT_LONG_MS = 12;
    localparam int DETECT_SHORT_CYC = DETECT_SHORT_MS * CLK_KHZ;
    localparam int DETECT_LONG_CYC = DETECT_LONG_MS * CLK_KHZ;

endpackage

//--- uerl_regs.sv
`timescale 1ns/10ps
module uerl_regs #(
    parameter int DETECT_SHORT_CYC = uerl_pkg::DETECT_SHORT_CYC,
    parameter int DETECT_LONG_CYC = uerl_pkg::DETECT_LONG_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // register port from the serial host front end
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // override bit held in the general register
    input wire logic equalizer_software_control_i,
    // strap pins
    input wire logic [1:0] general_equalizer_straps_i,
    input wire logic [1:0] upstream_equalizer_straps_i,
    // link side
    input wire logic lfps_detect_i,
    input wire logic low_power_state_i,
    input wire logic fsm_compliance_req_i,
    // equalizer levels applied to the receivers
    output logic [3:0] first_rx_equalizer_level_o,
    output logic [3:0] second_rx_equalizer_level_o,
    output logic [3:0] upstream_rx_equalizer_level_o,
    // link control
    output logic low_power_exit_o,
    output logic rx_detect_pulse_o,
    output logic compliance_status_o,
    output logic compliance_downstream_o,
    output logic compliance_upstream_o
);
    import uerl_pkg::*;

    localparam int DET_W = $clog2(DETECT_LONG_CYC + 1);
    localparam int DEB_W = $clog2(EXIT_DEBOUNCE_CYC + 1);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] strap_level(input logic [1:0] strap);
        logic [3:0] lvl;
        lvl = STRAP_LEVEL_0;
        unique case (strap)
            2'h0: lvl = STRAP_LEVEL_0;
            2'h1: lvl = STRAP_LEVEL_1;
            2'h2: lvl = STRAP_LEVEL_2;
            2'h3: lvl = STRAP_LEVEL_3;
        endcase
        return lvl;
    endfunction

    function automatic logic [3:0] lfps_level(input logic [3:0] lvl, input logic lfps,
                                              input logic keep);
        return (lfps && !keep) ? LFPS_ZERO_LEVEL : lvl;
    endfunction

    // one-hot select of the addressed register, zero when unmapped
    function automatic logic [2:0] reg_select(input logic [7:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        unique case (addr)
            MUX_EQ_OFFSET: sel = 3'h1;
            UP_EQ_OFFSET: sel = 3'h2;
            LINK_CTRL_OFFSET: sel = 3'h4;
            default: sel = 3'h0;
        endcase
        return sel;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync3_reg;
    logic [4:0] pin_stable_reg;
    logic [4:0] pins_raw;

    assign pins_raw = {lfps_detect_i, upstream_equalizer_straps_i, general_equalizer_straps_i};

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            sync3_reg <= 5'h00;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_pin
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    pin_stable_reg[gi] <= 1'b0;
                end else if (sync2_reg[gi] == sync3_reg[gi]) begin
                    pin_stable_reg[gi] <= sync3_reg[gi];
                end
            end
        end
    endgenerate

    logic [1:0] gen_strap;
    logic [1:0] up_strap;
    logic lfps_seen;

    assign gen_strap = pin_stable_reg[1:0];
    assign up_strap = pin_stable_reg[3:2];
    assign lfps_seen = pin_stable_reg[4];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0] second_eq_reg;
    logic [3:0] first_eq_reg;
    logic [3:0] up_eq_reg;
    logic [6:0] link_ctrl_reg;
    logic compliance_status_reg;
    logic wr_mux;
    logic wr_up;
    logic wr_link;
    logic [2:0] addr_sel;

    assign addr_sel = reg_select(reg_addr_i);
    assign wr_mux = reg_wr_i && addr_sel[0];
    assign wr_up = reg_wr_i && addr_sel[1];
    assign wr_link = reg_wr_i && addr_sel[2];

    // strap value tracks while override clear, software owns it while set
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            second_eq_reg <= MUX_EQ_RESET[SECOND_EQ_LSB +: EQ_FIELD_W];
        end else if (!equalizer_software_control_i) begin
            second_eq_reg <= strap_level(gen_strap);
        end else if (wr_mux) begin
            second_eq_reg <= reg_wdata_i[SECOND_EQ_LSB +: EQ_FIELD_W];
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            first_eq_reg <= MUX_EQ_RESET[FIRST_EQ_LSB +: EQ_FIELD_W];
        end else if (!equalizer_software_control_i) begin
            first_eq_reg <= strap_level(gen_strap);
        end else if (wr_mux) begin
            first_eq_reg <= reg_wdata_i[FIRST_EQ_LSB +: EQ_FIELD_W];
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up_eq_reg <= UP_EQ_RESET[UP_EQ_LSB +: EQ_FIELD_W];
        end else if (!equalizer_software_control_i) begin
            up_eq_reg <= strap_level(up_strap);
        end else if (wr_up) begin
            up_eq_reg <= reg_wdata_i[UP_EQ_LSB +: EQ_FIELD_W];
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link_ctrl_reg <= LINK_CTRL_RESET[6:0];
        end else if (wr_link) begin
            link_ctrl_reg <= reg_wdata_i[6:0] & LINK_CTRL_WMASK[6:0];
        end
    end

    logic keep_eq_in_lfps;
    logic debounce_on;
    logic detect_inhibit;
    logic [1:0] detect_period;
    logic [1:0] compliance_sel;

    assign keep_eq_in_lfps = link_ctrl_reg[LOW_FREQ_SIGNAL_EQUALIZE_BIT];
    assign debounce_on = link_ctrl_reg[EXIT_DEBOUNCE_BIT];
    assign detect_inhibit = link_ctrl_reg[DETECT_INHIBIT_BIT];
    assign detect_period = link_ctrl_reg[DETECT_PERIOD_LSB +: 2];
    assign compliance_sel = link_ctrl_reg[COMPLIANCE_SEL_LSB +: 2];

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= UNMAPPED_READ;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                MUX_EQ_OFFSET: reg_rdata_o <= {second_eq_reg, first_eq_reg};
                UP_EQ_OFFSET: reg_rdata_o <= {4'h0, up_eq_reg};
                LINK_CTRL_OFFSET: reg_rdata_o <= {compliance_status_reg, link_ctrl_reg};
                default: reg_rdata_o <= UNMAPPED_READ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // applied equalizer levels
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            first_rx_equalizer_level_o <= LFPS_ZERO_LEVEL;
        end else begin
            first_rx_equalizer_level_o <= lfps_level(first_eq_reg, lfps_seen,
                                                     keep_eq_in_lfps);
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            second_rx_equalizer_level_o <= LFPS_ZERO_LEVEL;
        end else begin
            second_rx_equalizer_level_o <= lfps_level(second_eq_reg, lfps_seen,
                                                      keep_eq_in_lfps);
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upstream_rx_equalizer_level_o <= LFPS_ZERO_LEVEL;
        end else begin
            upstream_rx_equalizer_level_o <= lfps_level(up_eq_reg, lfps_seen,
                                                        keep_eq_in_lfps);
        end
    end

    // ------------------------------------------------------------
    // low-power exit debounce
    // ------------------------------------------------------------
    logic [DEB_W-1:0] deb_cnt_reg;
    logic deb_done;

    assign deb_done = (deb_cnt_reg == DEB_W'(EXIT_DEBOUNCE_CYC));

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            deb_cnt_reg <= '0;
        end else if (!lfps_seen) begin
            deb_cnt_reg <= '0;
        end else if (!deb_done) begin
            deb_cnt_reg <= deb_cnt_reg + DEB_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_power_exit_o <= 1'b0;
        end else begin
            low_power_exit_o <= low_power_state_i && lfps_seen
                                && (!debounce_on || deb_done);
        end
    end

    // ------------------------------------------------------------
    // receiver detect timer
    // ------------------------------------------------------------
    logic [DET_W-1:0] det_cnt_reg;
    logic [DET_W-1:0] det_last;
    logic det_allowed;

    assign det_last = (detect_period == PERIOD_12MS) ? DET_W'(DETECT_LONG_CYC - 1)
                                                     : DET_W'(DETECT_SHORT_CYC - 1);
    assign det_allowed = !(detect_inhibit && low_power_state_i);

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            det_cnt_reg <= '0;
        end else if (det_cnt_reg >= det_last) begin
            det_cnt_reg <= '0;
        end else begin
            det_cnt_reg <= det_cnt_reg + DET_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_detect_pulse_o <= 1'b0;
        end else begin
            rx_detect_pulse_o <= det_allowed && (det_cnt_reg >= det_last);
        end
    end

    // ------------------------------------------------------------
    // compliance mode
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            compliance_status_reg <= 1'b0;
            compliance_status_o <= 1'b0;
            compliance_downstream_o <= 1'b0;
            compliance_upstream_o <= 1'b0;
        end else begin
            unique case (compliance_sel)
                COMPLIANCE_BY_FSM: begin
                    compliance_status_reg <= fsm_compliance_req_i;
                    compliance_status_o <= fsm_compliance_req_i;
                    compliance_downstream_o <= 1'b0;
                    compliance_upstream_o <= 1'b0;
                end
                COMPLIANCE_DOWNSTREAM: begin
                    compliance_status_reg <= 1'b1;
                    compliance_status_o <= 1'b1;
                    compliance_downstream_o <= 1'b1;
                    compliance_upstream_o <= 1'b0;
                end
                COMPLIANCE_UPSTREAM: begin
                    compliance_status_reg <= 1'b1;
                    compliance_status_o <= 1'b1;
                    compliance_downstream_o <= 1'b0;
                    compliance_upstream_o <= 1'b1;
                end
                COMPLIANCE_NEVER: begin
                    compliance_status_reg <= 1'b0;
                    compliance_status_o <= 1'b0;
                    compliance_downstream_o <= 1'b0;
                    compliance_upstream_o <= 1'b0;
                end
            endcase
        end
    end

endmodule

//--- uerl_host_model.sv
`timescale 1ns/10ps
module uerl_host_model (
    // clock
    input wire logic clk_sys_i,
    // register port
    input wire logic [7:0] reg_rdata_i,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_wr_o = 1'b0;
        // released lines show no stale value
        reg_wdata_o = ~d;
        reg_addr_o = ~a;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        @(posedge clk_sys_i);
        #1;
        d = reg_rdata_i;
    endtask
endmodule

//--- uerl_monitor.sv
`timescale 1ns/10ps
module uerl_monitor (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // link side
    input wire logic low_power_state_i,
    input wire logic low_power_exit_o,
    input wire logic rx_detect_pulse_o,
    input wire logic compliance_status_o,
    input wire logic compliance_downstream_o,
    input wire logic compliance_upstream_o
);
    default clocking mon_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    unmapped_read_a: assert property (
        reg_rd_i && (reg_addr_i < 8'h20 || reg_addr_i > 8'h22) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    up_reserved_a: assert property (
        reg_rd_i && reg_addr_i == 8'h21 |=> reg_rdata_o[7:4] == 4'h0)
        else $error("reserved bits of 0x21 not zero");
    status_read_a: assert property (
        reg_rd_i && reg_addr_i == 8'h22 |=> reg_rdata_o[7] == $past(compliance_status_o))
        else $error("status bit read mismatch");
    down_status_a: assert property (
        compliance_downstream_o |-> compliance_status_o)
        else $error("downstream forcing without status");
    up_status_a: assert property (
        compliance_upstream_o |-> compliance_status_o)
        else $error("upstream forcing without status");
    one_direction_a: assert property (
        !(compliance_downstream_o && compliance_upstream_o))
        else $error("both directions forced");
    exit_drop_a: assert property (
        !low_power_state_i |=> !low_power_exit_o)
        else $error("exit outside low power");
    pulse_single_a: assert property (
        rx_detect_pulse_o |=> !rx_detect_pulse_o [*8])
        else $error("detect pulses too close");
endmodule

//--- testbench.sv
`timescale 1ns/10ps
module testbench;
    import uerl_pkg::*;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic [7:0] reg_rdata_o;
    logic reg_wr_i;
    logic reg_rd_i;
    logic ovr = 1'b0;
    logic [1:0] gen_strap = 2'h2;
    logic [1:0] up_strap = 2'h3;
    logic lfps = 1'b0;
    logic low_pwr = 1'b0;
    logic fsm_req = 1'b1;
    logic [3:0] lv1, lv2, lvu;
    logic lp_exit, det, cm_st, cm_dn, cm_up;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    int n;

    // ------------------------------------------------------------
    // design and host
    // ------------------------------------------------------------
    uerl_regs #(.DETECT_SHORT_CYC(40), .DETECT_LONG_CYC(60)) DUT (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .equalizer_software_control_i(ovr), .general_equalizer_straps_i(gen_strap),
        .upstream_equalizer_straps_i(up_strap), .lfps_detect_i(lfps),
        .low_power_state_i(low_pwr), .fsm_compliance_req_i(fsm_req),
        .first_rx_equalizer_level_o(lv1), .second_rx_equalizer_level_o(lv2),
        .upstream_rx_equalizer_level_o(lvu), .low_power_exit_o(lp_exit),
        .rx_detect_pulse_o(det), .compliance_status_o(cm_st),
        .compliance_downstream_o(cm_dn), .compliance_upstream_o(cm_up));

    uerl_host_model host (
        .clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd_reg(a, d);
        chk({4'h0, d}, {4'h0, e});
    endtask

    // cycles between two detect pulses, 200 if none
    task automatic gap(output int k);
        k = 0;
        while (det !== 1'b1 && k < 200) begin
            cyc(1);
            k++;
        end
        cyc(1);
        k = 1;
        while (det !== 1'b1 && k < 200) begin
            cyc(1);
            k++;
        end
    endtask

    task automatic wait_exit(output int k);
        k = 0;
        while (lp_exit !== 1'b1 && k < 5000) begin
            cyc(1);
            k++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        cyc(5);
        arst_n_i = 1'b1;
        cyc(8);
        rchk(MUX_EQ_OFFSET, 8'h22);
        rchk(UP_EQ_OFFSET, 8'h03);
        chk({lv2, lv1, lvu}, 12'h223);
        rchk(LINK_CTRL_OFFSET, 8'h80);
        rchk(8'h23, 8'h00);
        host.wr_reg(MUX_EQ_OFFSET, 8'hA5);
        rchk(MUX_EQ_OFFSET, 8'h22);
        $display("test straps done");
        ovr = 1'b1;
        host.wr_reg(MUX_EQ_OFFSET, 8'hA5);
        host.wr_reg(UP_EQ_OFFSET, 8'hF7);
        rchk(MUX_EQ_OFFSET, 8'hA5);
        rchk(UP_EQ_OFFSET, 8'h07);
        chk({lv2, lv1, lvu}, 12'hA57);
        lfps = 1'b1;
        cyc(8);
        chk({lv2, lv1, lvu}, 12'h000);
        host.wr_reg(LINK_CTRL_OFFSET, 8'h40);
        cyc(3);
        chk({lv2, lv1, lvu}, 12'hA57);
        lfps = 1'b0;
        $display("test override done");
        for (int i = 0; i < 4; i++) begin
            host.wr_reg(LINK_CTRL_OFFSET, {6'h20, 2'(i)});
            cyc(2);
            chk({9'h0, cm_st, cm_dn, cm_up}, {9'h0, i != 3, i == 1, i == 2});
            rchk(LINK_CTRL_OFFSET, {i != 3, 5'h00, 2'(i)});
        end
        fsm_req = 1'b0;
        host.wr_reg(LINK_CTRL_OFFSET, 8'h00);
        cyc(3);
        chk({11'h0, cm_st}, 12'h000);
        $display("test compliance done");
        gap(n);
        chk(12'(n), 12'd40);
        host.wr_reg(LINK_CTRL_OFFSET, 8'h04);
        gap(n);
        chk(12'(n), 12'd60);
        low_pwr = 1'b1;
        host.wr_reg(LINK_CTRL_OFFSET, 8'h10);
        gap(n);
        chk(12'(n), 12'd200);
        $display("test detect done");
        host.wr_reg(LINK_CTRL_OFFSET, 8'h00);
        lfps = 1'b1;
        wait_exit(n);
        chk({11'h0, n <= 8}, 12'h001);
        lfps = 1'b0;
        cyc(6);
        host.wr_reg(LINK_CTRL_OFFSET, 8'h20);
        lfps = 1'b1;
        wait_exit(n);
        chk({11'h0, n >= 4000 && n <= 4008}, 12'h001);
        low_pwr = 1'b0;
        cyc(2);
        chk({11'h0, lp_exit}, 12'h000);
        $display("test debounce done");
        lfps = 1'b0;
        arst_n_i = 1'b0;
        cyc(2);
        arst_n_i = 1'b1;
        cyc(2);
        rchk(MUX_EQ_OFFSET, MUX_EQ_RESET);
        rchk(UP_EQ_OFFSET, UP_EQ_RESET);
        rchk(LINK_CTRL_OFFSET, LINK_CTRL_RESET);
        chk({lv2, lv1, lvu}, 12'h000);
        $display("test reset done");
        stop_test();
    end
endmodule

bind uerl_regs uerl_monitor u_mon (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .low_power_state_i(low_power_state_i),
    .low_power_exit_o(low_power_exit_o), .rx_detect_pulse_o(rx_detect_pulse_o),
    .compliance_status_o(compliance_status_o),
    .compliance_downstream_o(compliance_downstream_o),
    .compliance_upstream_o(compliance_upstream_o));
